// ===== index_ea.sv
`timescale 1ns/1ps
module index_ea (
  // Operand description.
  input wire logic [7:0] post,
  input wire logic [15:0] ofs16,
  input wire logic allow_long,
  // Register values.
  input wire paging_pkg::regs_type regs,
  input wire logic [15:0] pc_ref,
  // Result.
  output logic [15:0] ea,
  output logic indirect,
  output paging_pkg::wb_type wb,
  output logic illegal
);
  import paging_pkg::*;

  logic [15:0] base;
  logic [15:0] delta;
  logic [15:0] moved;
  reg_sel_type rr;

  always_comb begin
    if (post[7:5] == IDX_EXT_CODE) begin
      rr = reg_sel_type'(post[IDX_XRR_HI:IDX_XRR_LO]);
    end else begin
      rr = reg_sel_type'(post[IDX_RR_HI:IDX_RR_LO]);
    end
    unique case (rr)
      sel_x: base = regs.x;
      sel_y: base = regs.y;
      sel_sp: base = regs.sp;
      sel_pc: base = pc_ref;
    endcase
    delta = post[IDX_NEG_BIT] ? {12'hFFF, post[3:0]} : {12'h000, post[3:0]} + 16'h0001;
    moved = base + delta;
    ea = base;
    indirect = 1'b0;
    illegal = 1'b0;
    wb = '0;
    if (!post[IDX_LONG_BIT]) begin
      ea = base + {{11{post[4]}}, post[4:0]};
    end else if (post[7:5] != IDX_EXT_CODE) begin
      ea = post[IDX_POST_BIT] ? base : moved;
      wb = '{valid: 1'b1, sel: rr, value: moved};
      illegal = (rr == sel_pc);
    end else if (post[IDX_ACC_BIT]) begin
      unique case (post[1:0])
        2'h0: ea = base + {8'h00, regs.a};
        2'h1: ea = base + {8'h00, regs.b};
        2'h2: ea = base + {regs.a, regs.b};
        2'h3: begin
          ea = base + {regs.a, regs.b};
          indirect = 1'b1;
          illegal = !allow_long;
        end
      endcase
    end else begin
      illegal = !allow_long;
      unique case (post[1:0])
        2'h0, 2'h1: ea = base + {{8{post[0]}}, ofs16[7:0]};
        2'h2: ea = base + ofs16;
        2'h3: begin
          ea = base + ofs16;
          indirect = 1'b1;
        end
      endcase
    end
  end
endmodule

// ===== mmop_mem.sv
`timescale 1ns/1ps
module mmop_mem (
  // Clock.
  input wire logic clk_sys,
  // Memory bus.
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_word,
  input wire logic [21:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [7:0] m [int];
  int lat = 0;
  int a;
  initial mem_ack = 1'b0;
  initial mem_rdata = 16'h0000;
  function automatic logic [7:0] rd(int i);
    return m.exists(i) ? m[i] : 8'hC3;
  endfunction
  // Random latency; idle read lines toggle so stale data never looks valid.
  always @(posedge clk_sys) begin
    a = int'(mem_addr);
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_ack || !mem_req) begin
      lat <= $urandom_range(0, 3);
    end else if (lat != 0) begin
      lat <= lat - 1;
    end else begin
      mem_ack <= 1'b1;
      if (mem_we && mem_word) begin
        m[a] = mem_wdata[15:8];
        m[a + 1] = mem_wdata[7:0];
      end else if (mem_we) begin
        m[a] = mem_wdata[7:0];
      end else begin
        mem_rdata <= mem_word ? {rd(a), rd(a + 1)} : {~rd(a), rd(a)};
      end
    end
  end
endmodule

// ===== multi_mode_operand_paging.sv
`timescale 1ns/1ps
// How it works
// - Source and destination use independent addressing modes.
// - Moves to an immediate destination are rejected.
// - Indexed base may be X, Y, SP or PC.
// - Moves allow only short indexed forms, except to an indexed-indirect destination.
// - PC reference is byte after instruction.
// - Next-instruction pointer kept internally, no correction.
// - Legacy byte moves skew the PC reference.
// - Legacy word moves skew the PC reference.
// - Clear/set change only masked bits of byte.
// - Bit branches test byte against immediate mask.
// - Branch target adds signed 8-bit displacement.
// - Window 8000 to BFFF maps paged memory.
// - 8-bit page register selects one of 256.
// - Paged call pushes page, return, loads page.
// - Non-indirect call takes page from immediate.
// - Indirect call reads target and page through pointer.
// - Paged return pops page and return address.
// - Paged call/return work without expanded memory.
// - Page switch happens inside call and return.
// - Queue offset and alignment hidden from software.
// - Three word fetches refill queue at target.
module multi_mode_operand_paging (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Configuration.
  input wire logic expanded_mem_pin,
  input wire logic legacy_queue,
  // Instruction command.
  input wire logic cmd_valid,
  input wire paging_pkg::instr_type cmd,
  input wire paging_pkg::regs_type regs,
  output logic cmd_ready,
  // Memory bus.
  output logic mem_req,
  output logic mem_we,
  output logic mem_word,
  output logic [paging_pkg::PHYS_W-1:0] mem_addr,
  output logic mem_paged,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // Completion and register updates.
  output logic done,
  output logic illegal,
  output logic pc_load,
  output logic [15:0] pc_value,
  output paging_pkg::wb_type sp_wb,
  output paging_pkg::wb_type src_wb,
  output paging_pkg::wb_type dst_wb,
  // Queue refill and page.
  output logic refill_valid,
  output logic [15:0] refill_data,
  output logic [7:0] program_page_reg
);
  import paging_pkg::*;

  state_type state_q, state_d;
  logic rst_meta_q, rst_n;
  logic exp_meta_q, exp_q;
  instr_type ins_q;
  logic [15:0] next_q, src_ea_q, dst_ea_q, sp_q, data_q, target_q, pc_final_q;
  logic [7:0] newpage_q, page_q;
  logic [1:0] fetch_cnt_q;
  logic illegal_q, indirect_q;
  wb_type src_wb_q, dst_wb_q;
  logic mem_req_q, mem_we_q, mem_word_q, mem_paged_q;
  logic [PHYS_W-1:0] mem_addr_q;
  logic [15:0] mem_wdata_q;
  logic done_q, pc_load_q, refill_valid_q;
  logic [15:0] refill_data_q;
  wb_type sp_wb_q;

  logic [15:0] next_pc, skew_src, skew_dst, ref_src, ref_dst, src_ea, dst_ea;
  logic is_move, bad;
  logic [15:0] src_idx_ea, dst_idx_ea;
  logic src_ind, dst_ind, src_bad, dst_bad;
  wb_type src_idx_wb, dst_idx_wb;
  logic acc_state, step;
  logic [15:0] bus_addr, bus_wdata, branch_target;
  logic bus_we, bus_word, taken;
  logic [PHYS_W-1:0] bus_phys;
  logic bus_hit;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      exp_meta_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      exp_meta_q <= expanded_mem_pin;
      exp_q <= exp_meta_q;
    end
  end

  // Reference point is the byte after the instruction; with legacy_queue set, moves with an indexed operand and no indexed-indirect one add a skew below.
  assign next_pc = cmd.addr + {13'h0000, cmd.len};
  assign is_move = (cmd.op == move_byte_op) || (cmd.op == move_word_op);

  always_comb begin
    skew_src = SKEW_NONE;
    skew_dst = SKEW_NONE;
    if (legacy_queue && is_move) begin
      if (cmd.src_mode == immediate_mode && cmd.dst_mode == indexed_mode) begin
        skew_dst = (cmd.op == move_byte_op) ? SKEW_B_IMM_IDX : SKEW_W_IMM_IDX;
      end else if (cmd.src_mode == extended_mode && cmd.dst_mode == indexed_mode) begin
        skew_dst = SKEW_EXT_IDX;
      end else if (cmd.src_mode == indexed_mode && cmd.dst_mode == extended_mode) begin
        skew_src = SKEW_IDX_EXT;
      end else if (cmd.src_mode == indexed_mode && cmd.dst_mode == indexed_mode) begin
        skew_src = SKEW_IDX_IDX_FIRST;
        skew_dst = SKEW_IDX_IDX_SECOND;
      end
    end
    ref_src = next_pc + skew_src;
    ref_dst = next_pc + skew_dst;
  end

  index_ea u_src_idx (
    .post(cmd.src_post),
    .ofs16(cmd.src_field),
    .allow_long(!is_move),
    .regs(regs),
    .pc_ref(ref_src),
    .ea(src_idx_ea),
    .indirect(src_ind),
    .wb(src_idx_wb),
    .illegal(src_bad)
  );

  index_ea u_dst_idx (
    .post(cmd.dst_post),
    .ofs16(cmd.dst_field),
    .allow_long(!is_move),
    .regs(regs),
    .pc_ref(ref_dst),
    .ea(dst_idx_ea),
    .indirect(dst_ind),
    .wb(dst_idx_wb),
    .illegal(dst_bad)
  );

  always_comb begin
    unique case (cmd.src_mode)
      direct_mode: src_ea = {8'h00, cmd.src_field[7:0]};
      indexed_mode, indexed_indirect_mode: src_ea = src_idx_ea;
      default: src_ea = cmd.src_field;
    endcase
    unique case (cmd.dst_mode)
      direct_mode: dst_ea = {8'h00, cmd.dst_field[7:0]};
      indexed_mode, indexed_indirect_mode: dst_ea = dst_idx_ea;
      default: dst_ea = cmd.dst_field;
    endcase
    bad = 1'b0;
    unique case (cmd.op)
      move_byte_op, move_word_op: begin
        bad = (cmd.dst_mode == immediate_mode) || (cmd.dst_mode == direct_mode);
        bad = bad || (cmd.src_mode == direct_mode) || (cmd.src_mode > indexed_mode);
        bad = bad || (cmd.src_mode == indexed_mode && src_bad);
        bad = bad || (cmd.dst_mode == indexed_mode && dst_bad);
      end
      call_paged_op: begin
        bad = (cmd.dst_mode == immediate_mode) || (cmd.dst_mode == direct_mode);
        bad = bad || (cmd.dst_mode == indexed_mode && (dst_bad || dst_ind));
        bad = bad || (cmd.dst_mode == indexed_indirect_mode && !dst_ind);
      end
      return_paged_op: bad = 1'b0;
      default: begin
        bad = (cmd.dst_mode == immediate_mode) || (cmd.dst_mode > indexed_mode);
        bad = bad || (cmd.dst_mode == indexed_mode && (dst_bad || dst_ind));
      end
    endcase
  end

  assign acc_state = (state_q != st_idle) && (state_q != st_done);
  assign step = mem_req_q && mem_ack;
  assign branch_target = next_q + {{8{ins_q.rel[7]}}, ins_q.rel};

  always_comb begin
    if (ins_q.op == branch_if_masked_clear_op) begin
      taken = (mem_rdata[7:0] & ins_q.mask) == 8'h00;
    end else begin
      taken = (~mem_rdata[7:0] & ins_q.mask) == 8'h00;
    end
  end

  always_comb begin
    bus_addr = dst_ea_q;
    bus_we = 1'b0;
    bus_word = 1'b0;
    bus_wdata = 16'h0000;
    unique case (state_q)
      st_ptr: bus_word = 1'b1;
      st_pgrd: bus_addr = dst_ea_q + PAGE_PTR_OFS;
      st_src: begin
        bus_addr = (ins_q.op == move_byte_op || ins_q.op == move_word_op) ? src_ea_q : dst_ea_q;
        bus_word = (ins_q.op == move_word_op);
      end
      st_dst: begin
        bus_we = 1'b1;
        bus_word = (ins_q.op == move_word_op);
        unique case (ins_q.op)
          clear_masked_bits_op: bus_wdata = {8'h00, data_q[7:0] & ~ins_q.mask};
          set_masked_bits_op: bus_wdata = {8'h00, data_q[7:0] | ins_q.mask};
          default: bus_wdata = data_q;
        endcase
      end
      st_push_pg: begin
        bus_addr = sp_q + FRAME_PAGE_OFS;
        bus_we = 1'b1;
        bus_wdata = {8'h00, page_q};
      end
      st_push_ret: begin
        bus_addr = sp_q + FRAME_RET_OFS;
        bus_we = 1'b1;
        bus_word = 1'b1;
        bus_wdata = next_q;
      end
      st_pop_pg: bus_addr = sp_q;
      st_pop_ret: begin
        bus_addr = sp_q + 16'h0001;
        bus_word = 1'b1;
      end
      st_fetch: begin
        bus_addr = {target_q[15:1], 1'b0} + {13'h0000, fetch_cnt_q, 1'b0};
        bus_word = 1'b1;
      end
      default: bus_addr = dst_ea_q;
    endcase
  end

  page_map u_map (
    .logical(bus_addr),
    .page(page_q),
    .expanded(exp_q),
    .phys(bus_phys),
    .hit(bus_hit)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_word_q <= 1'b0;
      mem_addr_q <= '0;
      mem_paged_q <= 1'b0;
      mem_wdata_q <= 16'h0000;
    end else if (step) begin
      mem_req_q <= 1'b0;
    end else if (acc_state && !mem_req_q) begin
      mem_req_q <= 1'b1;
      mem_we_q <= bus_we;
      mem_word_q <= bus_word;
      mem_addr_q <= bus_phys;
      mem_paged_q <= bus_hit;
      mem_wdata_q <= bus_wdata;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_idle: begin
        if (cmd_valid) begin
          if (bad) begin
            state_d = st_done;
          end else begin
            unique case (cmd.op)
              move_byte_op, move_word_op: begin
                state_d = (cmd.src_mode == immediate_mode) ? st_dst : st_src;
              end
              call_paged_op: begin
                state_d = (cmd.dst_mode == indexed_indirect_mode) ? st_ptr : st_push_pg;
              end
              return_paged_op: state_d = st_pop_pg;
              default: state_d = st_src;
            endcase
          end
        end
      end
      st_ptr: state_d = step ? st_pgrd : st_ptr;
      st_pgrd: state_d = step ? st_push_pg : st_pgrd;
      st_src: begin
        if (step) begin
          if (ins_q.op == branch_if_masked_clear_op || ins_q.op == branch_if_masked_set_op) begin
            state_d = taken ? st_fetch : st_done;
          end else begin
            state_d = st_dst;
          end
        end
      end
      st_dst: state_d = step ? st_done : st_dst;
      st_push_pg: state_d = step ? st_push_ret : st_push_pg;
      st_push_ret: state_d = step ? st_fetch : st_push_ret;
      st_pop_pg: state_d = step ? st_pop_ret : st_pop_pg;
      st_pop_ret: state_d = step ? st_fetch : st_pop_ret;
      st_fetch: state_d = (step && fetch_cnt_q == REFILL_WORDS - 2'h1) ? st_done : st_fetch;
      st_done: state_d = st_idle;
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ins_q <= '0;
      next_q <= 16'h0000;
      src_ea_q <= 16'h0000;
      dst_ea_q <= 16'h0000;
      sp_q <= 16'h0000;
      illegal_q <= 1'b0;
      indirect_q <= 1'b0;
      src_wb_q <= '0;
      dst_wb_q <= '0;
    end else if (state_q == st_idle && cmd_valid) begin
      ins_q <= cmd;
      next_q <= next_pc;
      src_ea_q <= src_ea;
      dst_ea_q <= dst_ea;
      sp_q <= regs.sp;
      illegal_q <= bad;
      indirect_q <= (cmd.dst_mode == indexed_indirect_mode);
      src_wb_q <= (is_move && cmd.src_mode == indexed_mode && !bad) ? src_idx_wb : '0;
      dst_wb_q <= (cmd.dst_mode == indexed_mode && !bad) ? dst_idx_wb : '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= 16'h0000;
      target_q <= 16'h0000;
      newpage_q <= PAGE_RST;
      pc_final_q <= 16'h0000;
      fetch_cnt_q <= 2'h0;
    end else if (state_q == st_idle && cmd_valid) begin
      data_q <= cmd.src_field;
      target_q <= dst_ea;
      newpage_q <= cmd.page;
      pc_final_q <= next_pc;
      fetch_cnt_q <= 2'h0;
    end else if (step) begin
      unique case (state_q)
        st_ptr: target_q <= mem_rdata;
        st_pgrd: newpage_q <= mem_rdata[7:0];
        st_src: begin
          data_q <= mem_rdata;
          target_q <= branch_target;
          pc_final_q <= taken && !(ins_q.op == move_byte_op || ins_q.op == move_word_op)
                        && (ins_q.op == branch_if_masked_clear_op
                            || ins_q.op == branch_if_masked_set_op) ? branch_target : next_q;
        end
        st_push_ret: pc_final_q <= target_q;
        st_pop_pg: newpage_q <= mem_rdata[7:0];
        st_pop_ret: begin
          target_q <= mem_rdata;
          pc_final_q <= mem_rdata;
        end
        st_fetch: fetch_cnt_q <= fetch_cnt_q + 2'h1;
        default: data_q <= data_q;
      endcase
    end
  end

  // The page register lives in this block and changes inside the instruction itself.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      page_q <= PAGE_RST;
    end else if (step && (state_q == st_push_ret || state_q == st_pop_ret)) begin
      page_q <= newpage_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      pc_load_q <= 1'b0;
      sp_wb_q <= '0;
      refill_valid_q <= 1'b0;
      refill_data_q <= 16'h0000;
    end else begin
      done_q <= (state_q == st_done);
      pc_load_q <= (state_q == st_done) && !illegal_q;
      sp_wb_q.valid <= (state_q == st_done) && !illegal_q
                       && (ins_q.op == call_paged_op || ins_q.op == return_paged_op);
      sp_wb_q.sel <= sel_sp;
      sp_wb_q.value <= (ins_q.op == call_paged_op) ? sp_q - FRAME_SIZE : sp_q + FRAME_SIZE;
      refill_valid_q <= step && (state_q == st_fetch);
      refill_data_q <= mem_rdata;
    end
  end

  assign cmd_ready = (state_q == st_idle) && rst_n;
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_word = mem_word_q;
  assign mem_addr = mem_addr_q;
  assign mem_paged = mem_paged_q;
  assign mem_wdata = mem_wdata_q;
  assign done = done_q;
  assign illegal = done_q && illegal_q;
  assign pc_load = pc_load_q;
  assign pc_value = pc_final_q;
  assign sp_wb = sp_wb_q;
  assign src_wb = pc_load_q ? src_wb_q : '0;
  assign dst_wb = pc_load_q ? dst_wb_q : '0;
  assign refill_valid = refill_valid_q;
  assign refill_data = refill_data_q;
  assign program_page_reg = page_q;
endmodule

// ===== multi_mode_operand_paging_sva.sv
`timescale 1ns/1ps
module multi_mode_operand_paging_sva (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Command and completion.
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic done,
  input wire logic illegal,
  input wire logic pc_load,
  input wire paging_pkg::wb_type sp_wb,
  // Memory side.
  input wire logic mem_req,
  input wire logic [paging_pkg::PHYS_W-1:0] mem_addr,
  input wire logic mem_paged,
  input wire logic mem_ack,
  input wire logic refill_valid,
  input wire logic [7:0] program_page_reg
);
  import paging_pkg::*;
  logic [2:0] fills_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fills_q <= 3'h0;
    end else if (cmd_valid && cmd_ready) begin
      fills_q <= 3'h0;
    end else begin
      fills_q <= fills_q + {2'h0, refill_valid};
    end
  end
  a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("request moved before ack");
  a_req_drop: assert property (mem_ack |=> !mem_req)
    else $error("request held after ack");
  a_page_map: assert property (mem_req && mem_paged |-> mem_addr[21:14] == program_page_reg)
    else $error("window not mapped by page");
  a_low_space: assert property (mem_req && !mem_paged |-> mem_addr[21:16] == 6'h00)
    else $error("unpaged access above 64K");
  a_page_flow: assert property ($changed(program_page_reg) |-> $past(mem_ack))
    else $error("page changed outside ack");
  a_refill_three: assert property (done && sp_wb.valid |-> fills_q + {2'h0, refill_valid} == 3'h3)
    else $error("refill count wrong");
  a_illegal_quiet: assert property (illegal |-> done && !pc_load && !mem_req)
    else $error("reject not clean");
  a_sp_frame: assert property (sp_wb.valid |-> done && pc_load)
    else $error("stack update outside end");
  c_call_done: cover property (done && sp_wb.valid);
  c_rejected: cover property (illegal);
  c_paged_req: cover property (mem_req && mem_paged);
endmodule
bind multi_mode_operand_paging multi_mode_operand_paging_sva
  multi_mode_operand_paging_sva_inst (.*);

// ===== page_map.sv
`timescale 1ns/1ps
module page_map (
  // Logical side.
  input wire logic [15:0] logical,
  input wire logic [7:0] page,
  input wire logic expanded,
  // Physical side.
  output logic [paging_pkg::PHYS_W-1:0] phys,
  output logic hit
);
  import paging_pkg::*;

  always_comb begin
    hit = expanded && (logical >= WIN_LO) && (logical <= WIN_HI);
    if (hit) begin
      phys = {page, logical[WIN_OFS_W-1:0]};
    end else begin
      phys = {6'h00, logical};
    end
  end
endmodule

// ===== paging_pkg.sv
package paging_pkg;

  // Program memory window and page register.
  localparam logic [15:0] WIN_LO = 16'h8000;
  localparam logic [15:0] WIN_HI = 16'hBFFF;
  localparam int WIN_OFS_W = 14;
  localparam int PHYS_W = 22;
  localparam logic [7:0] PAGE_RST = 8'h00;

  // Queue refill after a change of flow.
  localparam logic [1:0] REFILL_WORDS = 2'h3;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // Stack frame of a paged call: page byte on top of the return word.
  localparam logic [15:0] FRAME_PAGE_OFS = 16'hFFFD;
  localparam logic [15:0] FRAME_RET_OFS = 16'hFFFE;
  localparam logic [15:0] FRAME_SIZE = 16'h0003;
  localparam logic [15:0] PAGE_PTR_OFS = 16'h0002;

  // Reference skews of the legacy queue variant.
  localparam logic [15:0] SKEW_NONE = 16'h0000;
  localparam logic [15:0] SKEW_B_IMM_IDX = 16'h0001;
  localparam logic [15:0] SKEW_W_IMM_IDX = 16'h0002;
  localparam logic [15:0] SKEW_EXT_IDX = 16'h0002;
  localparam logic [15:0] SKEW_IDX_EXT = 16'hFFFE;
  localparam logic [15:0] SKEW_IDX_IDX_FIRST = 16'hFFFF;
  localparam logic [15:0] SKEW_IDX_IDX_SECOND = 16'h0001;

  // Indexed postbyte fields.
  localparam int IDX_RR_HI = 7;
  localparam int IDX_RR_LO = 6;
  localparam int IDX_XRR_HI = 4;
  localparam int IDX_XRR_LO = 3;
  localparam int IDX_LONG_BIT = 5;
  localparam int IDX_POST_BIT = 4;
  localparam int IDX_NEG_BIT = 3;
  localparam int IDX_ACC_BIT = 2;
  localparam logic [2:0] IDX_EXT_CODE = 3'h7;

  typedef enum logic [2:0] {
    move_byte_op, move_word_op, clear_masked_bits_op, set_masked_bits_op,
    branch_if_masked_clear_op, branch_if_masked_set_op, call_paged_op, return_paged_op
  } op_type;

  typedef enum logic [2:0] {
    immediate_mode, direct_mode, extended_mode, indexed_mode, indexed_indirect_mode
  } mode_type;

  typedef enum logic [1:0] {sel_x, sel_y, sel_sp, sel_pc} reg_sel_type;

  typedef struct packed {
    op_type op;
    mode_type src_mode;
    mode_type dst_mode;
    logic [15:0] src_field;
    logic [15:0] dst_field;
    logic [7:0] src_post;
    logic [7:0] dst_post;
    logic [7:0] mask;
    logic [7:0] rel;
    logic [7:0] page;
    logic [15:0] addr;
    logic [2:0] len;
  } instr_type;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] sp;
  } regs_type;

  typedef struct packed {
    logic valid;
    reg_sel_type sel;
    logic [15:0] value;
  } wb_type;

  typedef enum logic [3:0] {
    st_idle = 4'h0, st_ptr = 4'h1, st_pgrd = 4'h3, st_src = 4'h2,
    st_dst = 4'h6, st_push_pg = 4'h7, st_push_ret = 4'h5, st_pop_pg = 4'h4,
    st_pop_ret = 4'hC, st_fetch = 4'hD, st_done = 4'hF
  } state_type;

endpackage

// ===== test_multi_mode_operand_paging.sv
`timescale 1ns/1ps
module test_multi_mode_operand_paging;
  import paging_pkg::*;
  logic clk_sys, arst_n, expanded_mem_pin, legacy_queue, cmd_valid, cmd_ready, ill, tk;
  logic mem_req, mem_we, mem_word, mem_paged, mem_ack, done, illegal, pc_load, refill_valid;
  logic [PHYS_W-1:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata, pc_value, w, ea, pcv, spv, tgt, dwb;
  logic [7:0] program_page_reg, v, mk, pg;
  logic [7:0] pgs [3];
  instr_type cmd, c;
  regs_type regs, r;
  wb_type sp_wb, dst_wb;
  int cyc = 0;
  int error_cnt = 0;
  int num_checks = 0;
  multi_mode_operand_paging multi_mode_operand_paging_inst (
    .src_wb(), .refill_data(), .*);
  mmop_mem mmop_mem_inst (.*);
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic run();
    int n;
    n = 0;
    @(posedge clk_sys);
    cmd <= c;
    regs <= r;
    cmd_valid <= 1'b1;
    do @(negedge clk_sys); while (cmd_ready !== 1'b1 && ++n < 50);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    do @(negedge clk_sys); while (done !== 1'b1 && ++n < 300);
    chk("done", n < 300, 16'h0001);
    ill = illegal;
    pcv = pc_value;
    spv = sp_wb.value;
    dwb = dst_wb.value;
    pg = program_page_reg;
  endtask
  initial begin
    {clk_sys, arst_n, cmd_valid, legacy_queue} = 4'h0;
    expanded_mem_pin = 1'b1;
    cmd = '0;
    regs = '0;
    r = '{8'h00, 8'h00, 16'h1100, 16'h1200, 16'h1300};
    void'($urandom(55));
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      c = '0;
      c.op = i == 3 ? clear_masked_bits_op : move_byte_op;
      c.src_mode = i == 2 ? indexed_indirect_mode : indexed_mode;
      c.src_post = i == 1 ? 8'hE0 : 8'h00;
      c.dst_mode = (i == 1 || i == 2) ? extended_mode : immediate_mode;
      c.len = 3'h4;
      run();
      chk("rejected", ill, 16'h0001);
    end
    for (int j = 0; j < 32; j++) begin
      w = 16'($urandom);
      mmop_mem_inst.m[32'h2000] = w[15:8];
      mmop_mem_inst.m[32'h2001] = w[7:0];
      @(posedge clk_sys);
      legacy_queue <= j[3];
      c = '0;
      c.op = j[2] ? move_word_op : move_byte_op;
      c.src_mode = j[4] ? extended_mode : immediate_mode;
      c.dst_mode = indexed_mode;
      c.src_field = j[4] ? 16'h2000 : w;
      c.dst_post = j[1:0] == 2'h2 ? 8'hB0 : {j[1:0], 6'h03};
      c.addr = 16'h1400;
      c.len = 3'h5;
      ea = j[1:0] == 2'h3 ? 16'h1408 : 16'h1103 + {6'h00, j[1:0], 8'h00};
      if (j[1:0] == 2'h2) ea = 16'h1300;
      if (j[3] && j[1:0] == 2'h3) ea = ea + ((j[4] || j[2]) ? 16'h0002 : 16'h0001);
      run();
      chk("move", mmop_mem_inst.m[ea], (j[4] || j[2]) ? w[15:8] : w[7:0]);
      chk("legal", ill, 16'h0000);
      chk("index update", dwb, j[1:0] == 2'h2 ? 16'h1301 : 16'h0000);
    end
    for (int k = 0; k < 8; k++) begin
      v = 8'($urandom);
      mk = 8'($urandom);
      if (k[2]) v = k[0] ? v | mk : v & ~mk;
      mmop_mem_inst.m[32'h0040 + k] = v;
      c = '0;
      c.op = op_type'(k % 4 + 2);
      c.dst_mode = k[2] ? direct_mode : extended_mode;
      c.dst_field = 16'h0040 + 16'(k);
      c.mask = mk;
      c.rel = 8'($urandom);
      c.addr = 16'h5000;
      c.len = 3'h5;
      run();
      tk = k[0] ? (~v & mk) == 8'h00 : (v & mk) == 8'h00;
      if (k[1]) begin
        chk("branch", pcv, 16'h5005 + (tk ? {{8{c.rel[7]}}, c.rel} : 16'h0000));
      end else begin
        chk("bits", mmop_mem_inst.m[32'h0040 + k], k[0] ? v | mk : v & ~mk);
      end
    end
    for (int e = 0; e < 3; e++) begin
      if (e == 2) begin
        @(posedge clk_sys);
        expanded_mem_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
      end
      pgs[e] = program_page_reg;
      tgt = 16'h8000 + 16'($urandom_range(0, 8191)) * 16'h0002;
      v = e == 0 ? 8'hFF : 8'($urandom);
      c = '0;
      c.op = call_paged_op;
      c.addr = 16'h0600 + 16'(e * 16);
      c.len = 3'h4;
      c.dst_mode = extended_mode;
      c.dst_field = tgt;
      c.page = v;
      r.sp = 16'h0F00 - 16'(e * 3);
      r.x = 16'h0700;
      if (e == 1) begin
        c.dst_mode = indexed_indirect_mode;
        c.dst_post = 8'hE3;
        c.dst_field = 16'h0010;
        c.page = ~v;
        mmop_mem_inst.m[32'h0710] = tgt[15:8];
        mmop_mem_inst.m[32'h0711] = tgt[7:0];
        mmop_mem_inst.m[32'h0712] = v;
      end
      run();
      chk("call page", pg, v);
      chk("call pc", pcv, tgt);
      chk("call sp", spv, r.sp - 16'h0003);
    end
    for (int e = 2; e >= 0; e--) begin
      c = '0;
      c.op = return_paged_op;
      c.len = 3'h1;
      c.addr = 16'h9000;
      r.sp = 16'h0EFD - 16'(e * 3);
      run();
      chk("ret page", pg, pgs[e]);
      chk("ret pc", pcv, 16'h0604 + 16'(e * 16));
      chk("ret sp", spv, r.sp + 16'h0003);
    end
    final_report();
  end
endmodule
